// *** inc/tnhim_cfg.svh ***
// constants for the channel 0 transmit nibble / link-byte input mux
// assumes inclusion by bare name from package and design files
`ifndef TNHIM_CFG_SVH
`define TNHIM_CFG_SVH

`define TNHIM_NIB_W        4
`define TNHIM_BYTE_W       8
`define TNHIM_WORD_W       9
`define TNHIM_FLAG_BIT     8
`define TNHIM_FIFO_DEPTH   8
`define TNHIM_UPPER_RST    4'h0
`define TNHIM_WORD_RST     9'h000
`define TNHIM_LINK_RST_CYC 7'h40

`endif

// *** inc/tnhim_pkg.sv ***
// types for the transmit nibble / link-byte input mux
// assumes tnhim_cfg.svh is on the include path
`include "tnhim_cfg.svh"

package tnhim_pkg;

  typedef logic [`TNHIM_WORD_W-1:0] tnhim_word_t;

  typedef enum logic [1:0] {
    TNHIM_ROUTE_IDLE   = 2'h0,
    TNHIM_ROUTE_NIBBLE = 2'h1,
    TNHIM_ROUTE_LINK   = 2'h3
  } tnhim_route_t;

endpackage

// *** logic/tnhim_fifo.sv ***
// dual-clock fifo, gray pointers, registered read data
// assumes each side's reset is synchronous to its own clock
`timescale 1ns/1ps

module tnhim_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             wrClk,
  input  wire logic             wrRst,
  input  wire logic             wrValid,
  output logic                  wrReady,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic             rdClk,
  input  wire logic             rdRst,
  output logic                  rdValid,
  input  wire logic             rdReady,
  output logic      [WIDTH-1:0] rdData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrBin_q, wrGray_q, rdBin_q, rdGray_q;
  logic [AW:0]      wrSync1_q, wrSync2_q, rdSync1_q, rdSync2_q;
  logic [AW:0]      wrBin_d, wrGray_d, rdBin_d, rdGray_d;
  logic             empty_q;
  logic [WIDTH-1:0] rdData_q;
  wire              wrPush = wrValid & wrReady;
  wire              rdPop  = rdValid & rdReady;

  // full when write pointer is one lap ahead of the synced read pointer
  assign wrReady  = wrGray_q != {~rdSync2_q[AW:AW-1], rdSync2_q[AW-2:0]};
  assign wrBin_d  = wrBin_q + {{AW{1'b0}}, wrPush};
  assign wrGray_d = wrBin_d ^ (wrBin_d >> 1);
  assign rdBin_d  = rdBin_q + {{AW{1'b0}}, rdPop};
  assign rdGray_d = rdBin_d ^ (rdBin_d >> 1);
  assign rdValid  = ~empty_q;
  assign rdData   = rdData_q;

  always_ff @(posedge wrClk) begin
    if (wrPush) begin
      mem[wrBin_q[AW-1:0]] <= wrData;
    end
  end

  always_ff @(posedge wrClk) begin
    if (wrRst) begin
      wrBin_q   <= '0;
      wrGray_q  <= '0;
      rdSync1_q <= '0;
      rdSync2_q <= '0;
    end else begin
      wrBin_q   <= wrBin_d;
      wrGray_q  <= wrGray_d;
      rdSync1_q <= rdGray_q;
      rdSync2_q <= rdSync1_q;
    end
  end

  // empty and read data are taken from the same pointer so they never disagree
  always_ff @(posedge rdClk) begin
    if (rdRst) begin
      rdBin_q   <= '0;
      rdGray_q  <= '0;
      wrSync1_q <= '0;
      wrSync2_q <= '0;
      empty_q   <= 1'b1;
    end else begin
      rdBin_q   <= rdBin_d;
      rdGray_q  <= rdGray_d;
      wrSync1_q <= wrGray_q;
      wrSync2_q <= wrSync1_q;
      empty_q   <= rdGray_d == wrSync2_q;
    end
  end

  always_ff @(posedge rdClk) begin
    rdData_q <= mem[rdBin_d[AW-1:0]];
  end

endmodule // tnhim_fifo

// *** logic/tx_nibble_hdlc_input_mux.sv ***
// channel 0 transmit payload input: nibble or link-byte capture into the framer
// assumes mode levels come from ref_clk logic and pins are timed to the nibble clock
// Functional notes
// - shared pins routed by the channel mode
// - nibble mode: four bits form one payload nibble
// - pins captured on rising nibble clock edge
// - pins ignored unless nibble-parallel or link mode selected
// - link mode: bit 0 pin is byte bit 0
// - link mode: bit 3 pin is byte bit 3
`timescale 1ns/1ps
`include "tnhim_cfg.svh"

module tx_nibble_hdlc_input_mux
  import tnhim_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    linkModeEn,
  input  wire logic                    nibbleModeSel,
  input  wire logic                    txPayloadNibbleClock,
  input  wire logic                    txPayloadNibbleBit0,
  input  wire logic                    txPayloadNibbleBit1,
  input  wire logic                    txPayloadNibbleBit2,
  input  wire logic                    txPayloadNibbleBit3,
  input  wire logic [3:0]              txLinkByteUpper,
  output logic                         captureReady,
  output logic                         captureOverrun,
  output logic      [`TNHIM_NIB_W-1:0]  payloadNibble,
  output logic                         payloadValid,
  input  wire logic                    payloadReady,
  output logic      [`TNHIM_BYTE_W-1:0] linkByte,
  output logic                         linkByteValid,
  input  wire logic                    linkByteReady
);

  function automatic tnhim_route_t route_of(input logic link, input logic nib);
    if (link)     return TNHIM_ROUTE_LINK;
    else if (nib) return TNHIM_ROUTE_NIBBLE;
    else          return TNHIM_ROUTE_IDLE;
  endfunction

  // ---- link reset stretch, ref_clk side
  // rst may last only a few ref_clk cycles, far less than one nibble period,
  // so it is stretched here until the link side has surely seen it
  // limitation: the nibble clock must tick at least three times per stretch
  logic [6:0] rstCnt_q, rstCnt_d;
  logic       rstHold_q;
  logic       rdSideRst;
  wire        rstCntDone = rstCnt_q == 7'h00;

  assign rstCnt_d  = rstCntDone ? rstCnt_q : rstCnt_q - 7'h01;
  // framer read side stays in reset until the link side has been reset
  assign rdSideRst = rst | rstHold_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rstCnt_q  <= `TNHIM_LINK_RST_CYC;
      rstHold_q <= 1'b1;
    end else begin
      rstCnt_q  <= rstCnt_d;
      rstHold_q <= ~rstCntDone;
    end
  end

  // ---- link domain, clocked by the terminal's nibble clock
  logic         linkRst1_q, linkRst_q;
  logic         linkSync1_q, linkSync2_q, nibSync1_q, nibSync2_q;
  tnhim_word_t  capWord_q, capWord_d;
  logic         capValid_q, overrun_q;
  logic         fifoWrReady;
  tnhim_route_t linkRoute;
  wire  [3:0]   pinNibble = {txPayloadNibbleBit3, txPayloadNibbleBit2,
                             txPayloadNibbleBit1, txPayloadNibbleBit0};

  // reset reaches the link side only while the nibble clock runs
  always_ff @(posedge txPayloadNibbleClock) begin
    linkRst1_q <= rstHold_q;
    linkRst_q  <= linkRst1_q;
  end

  always_ff @(posedge txPayloadNibbleClock) begin
    if (linkRst_q) begin
      linkSync1_q <= 1'b0;
      linkSync2_q <= 1'b0;
      nibSync1_q  <= 1'b0;
      nibSync2_q  <= 1'b0;
    end else begin
      linkSync1_q <= linkModeEn;
      linkSync2_q <= linkSync1_q;
      nibSync1_q  <= nibbleModeSel;
      nibSync2_q  <= nibSync1_q;
    end
  end

  assign linkRoute = route_of(linkSync2_q, nibSync2_q);

  always_comb begin
    capWord_d = `TNHIM_WORD_RST;
    unique case (linkRoute)
      TNHIM_ROUTE_LINK:   capWord_d = {1'b1, txLinkByteUpper, pinNibble};
      TNHIM_ROUTE_NIBBLE: capWord_d = {1'b0, `TNHIM_UPPER_RST, pinNibble};
      TNHIM_ROUTE_IDLE:   capWord_d = `TNHIM_WORD_RST;
    endcase
  end

  // rising edge capture; far end is expected to move pins on the falling edge
  always_ff @(posedge txPayloadNibbleClock) begin
    if (linkRst_q) begin
      capWord_q  <= `TNHIM_WORD_RST;
      capValid_q <= 1'b0;
      overrun_q  <= 1'b0;
    end else begin
      capWord_q  <= capWord_d;
      capValid_q <= linkRoute != TNHIM_ROUTE_IDLE;
      overrun_q  <= capValid_q & ~fifoWrReady;
    end
  end

  // terminal cannot be stalled, so a full fifo drops the sample and flags it
  assign captureReady   = fifoWrReady;
  assign captureOverrun = overrun_q;

  // ---- crossing into the framer clock
  tnhim_word_t outWord_q, fifoRdData;
  logic        outValid_q, fifoRdValid, fifoRdReady;

  tnhim_fifo #(
    .WIDTH (`TNHIM_WORD_W),
    .DEPTH (`TNHIM_FIFO_DEPTH)
  ) u_fifo (
    .wrClk   (txPayloadNibbleClock),
    .wrRst   (linkRst_q),
    .wrValid (capValid_q),
    .wrReady (fifoWrReady),
    .wrData  (capWord_q),
    .rdClk   (ref_clk),
    .rdRst   (rdSideRst),
    .rdValid (fifoRdValid),
    .rdReady (fifoRdReady),
    .rdData  (fifoRdData)
  );

  // ---- framer side output stage
  wire outIsLink = outWord_q[`TNHIM_FLAG_BIT];
  wire accept    = (payloadValid & payloadReady) | (linkByteValid & linkByteReady);

  assign fifoRdReady   = ~outValid_q | accept;
  assign payloadValid  = outValid_q & ~outIsLink;
  assign linkByteValid = outValid_q & outIsLink;
  assign payloadNibble = outWord_q[`TNHIM_NIB_W-1:0];
  assign linkByte      = outWord_q[`TNHIM_BYTE_W-1:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      outWord_q  <= `TNHIM_WORD_RST;
      outValid_q <= 1'b0;
    end else if (fifoRdReady) begin
      outWord_q  <= fifoRdData;
      outValid_q <= fifoRdValid;
    end
  end

  // ---- checks
  route_tag_a: assert property (
    @(posedge txPayloadNibbleClock) disable iff (linkRst_q)
    capValid_q |-> capWord_q[`TNHIM_FLAG_BIT] == $past(linkSync2_q))
    else $error("captured word route flag disagrees with mode");

  nib_upper_zero_a: assert property (
    @(posedge txPayloadNibbleClock) disable iff (linkRst_q)
    capValid_q && !capWord_q[`TNHIM_FLAG_BIT] |-> capWord_q[7:4] == 4'h0)
    else $error("payload nibble word carries upper bits");

  nib_capture_a: assert property (
    @(posedge txPayloadNibbleClock) disable iff (linkRst_q)
    nibSync2_q && !linkSync2_q |=> capValid_q && capWord_q[3:0] == $past(pinNibble))
    else $error("nibble not captured on rising edge");

  idle_ignore_a: assert property (
    @(posedge txPayloadNibbleClock) disable iff (linkRst_q)
    !nibSync2_q && !linkSync2_q |=> !capValid_q)
    else $error("pins captured outside nibble or link mode");

  link_bit0_a: assert property (
    @(posedge txPayloadNibbleClock) disable iff (linkRst_q)
    linkSync2_q |=> capWord_q[0] == $past(txPayloadNibbleBit0))
    else $error("link byte bit 0 not from bit 0 pin");

  link_bit3_a: assert property (
    @(posedge txPayloadNibbleClock) disable iff (linkRst_q)
    linkSync2_q |=> capWord_q[3] == $past(txPayloadNibbleBit3)
      && capWord_q[7:4] == $past(txLinkByteUpper))
    else $error("link byte bit 3 not from bit 3 pin");

  out_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    outValid_q && !accept |=> outValid_q && $stable(outWord_q))
    else $error("framer output changed before acceptance");

  out_exclusive_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(payloadValid && linkByteValid))
    else $error("nibble and link byte offered together");

  ovr_drop_a: assert property (
    @(posedge txPayloadNibbleClock) disable iff (linkRst_q)
    capValid_q && !fifoWrReady |=> captureOverrun)
    else $error("dropped capture not flagged");

  quiet_reset_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    rstHold_q |-> !payloadValid && !linkByteValid)
    else $error("framer output offered during link reset");

  nib_seen_c:  cover property (@(posedge ref_clk) disable iff (rst)
    payloadValid && payloadReady);
  link_seen_c: cover property (@(posedge ref_clk) disable iff (rst)
    linkByteValid && linkByteReady);
  full_seen_c: cover property (@(posedge txPayloadNibbleClock) disable iff (linkRst_q)
    !fifoWrReady);
  ovr_seen_c:  cover property (@(posedge txPayloadNibbleClock) disable iff (linkRst_q)
    overrun_q);
  lrst_end_c:  cover property (@(posedge txPayloadNibbleClock)
    $fell(linkRst_q));

endmodule // tx_nibble_hdlc_input_mux

// *** verif/tnhim_term.sv ***
// terminal-equipment model: presents a counting word on the shared pins
// assumes the nibble clock runs; pins move on its falling edge only
`timescale 1ns/1ps

module tnhim_term (
  input  wire logic       nibClk,
  output logic            bit0,
  output logic            bit1,
  output logic            bit2,
  output logic            bit3,
  output logic      [3:0] upper
);
  logic [7:0] cnt_q = 8'h00;

  // falling-edge update keeps the capture edge clear of changing pins
  always @(negedge nibClk) begin
    cnt_q <= cnt_q + 8'h01;
  end

  assign {upper, bit3, bit2, bit1, bit0} = cnt_q;

endmodule // tnhim_term

// *** verif/tb.sv ***
// self-checking bench for the transmit nibble / link-byte input mux
// assumes the terminal model counts up by one per nibble-clock cycle
`timescale 1ns/1ps

`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module tb;
  logic       refClk        = 1'b0;
  logic       rst           = 1'b1;
  logic       nibClk        = 1'b0;
  logic       linkModeEn    = 1'b0;
  logic       nibbleModeSel = 1'b1;
  logic       payloadReady  = 1'b1;
  logic       linkByteReady = 1'b1;
  wire  logic b0, b1, b2, b3;
  wire  logic [3:0] upper;
  logic       captureReady, captureOverrun, payloadValid, linkByteValid;
  logic [3:0] payloadNibble;
  logic [7:0] linkByte;
  logic [7:0] nibQ[$];
  logic [7:0] byteQ[$];
  logic       ovrSeen = 1'b0;
  int         cycles  = 0;
  int         fails   = 0;
  int         nChecks = 0;

  always #2.5 refClk = ~refClk;
  // link clock offset so its rising edges never line up with the framer clock's
  initial begin
    #7;
    forever #16 nibClk = ~nibClk;
  end

  tnhim_term term (.nibClk(nibClk), .bit0(b0), .bit1(b1), .bit2(b2), .bit3(b3), .upper(upper));

  tx_nibble_hdlc_input_mux DUT (
    .ref_clk(refClk), .rst(rst), .linkModeEn(linkModeEn), .nibbleModeSel(nibbleModeSel),
    .txPayloadNibbleClock(nibClk), .txPayloadNibbleBit0(b0), .txPayloadNibbleBit1(b1),
    .txPayloadNibbleBit2(b2), .txPayloadNibbleBit3(b3), .txLinkByteUpper(upper),
    .captureReady(captureReady), .captureOverrun(captureOverrun),
    .payloadNibble(payloadNibble), .payloadValid(payloadValid), .payloadReady(payloadReady),
    .linkByte(linkByte), .linkByteValid(linkByteValid), .linkByteReady(linkByteReady));

  task stop_test;
    if (fails == 0 && nChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge refClk) begin
    cycles++;
    if (payloadValid === 1'b1 && payloadReady === 1'b1) nibQ.push_back({4'h0, payloadNibble});
    if (linkByteValid === 1'b1 && linkByteReady === 1'b1) byteQ.push_back(linkByte);
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  always @(posedge nibClk) begin
    if (captureOverrun === 1'b1) ovrSeen = 1'b1;
  end

  task wait_ref(input int n);
    repeat (n) @(posedge refClk);
  endtask

  // words must come out whole and in capture order, one per nibble-clock cycle
  task chk_seq(input logic [7:0] q[$], input logic [7:0] mask);
    `CHK(q.size() >= 8, 1'b1)
    for (int i = 1; i < 8; i++)
      `CHK(q[i], (q[i-1] + 8'h01) & mask)
  endtask

  task test_nibble;
    nibQ.delete();
    byteQ.delete();
    wait_ref(300);
    chk_seq(nibQ, 8'h0f);
    `CHK(byteQ.size(), 0)
  endtask

  // both mode levels high: link mode must win
  task test_link;
    @(posedge refClk) linkModeEn <= 1'b1;
    wait_ref(100);
    nibQ.delete();
    byteQ.delete();
    wait_ref(300);
    chk_seq(byteQ, 8'hff);
    `CHK(nibQ.size(), 0)
  endtask

  task test_idle;
    @(posedge refClk) begin
      linkModeEn    <= 1'b0;
      nibbleModeSel <= 1'b0;
    end
    wait_ref(100);
    nibQ.delete();
    byteQ.delete();
    wait_ref(300);
    `CHK(nibQ.size() + byteQ.size(), 0)
  endtask

  // framer stalls; terminal cannot, so the buffer fills and samples drop
  task test_full;
    ovrSeen = 1'b0;
    @(posedge refClk) begin
      nibbleModeSel <= 1'b1;
      payloadReady  <= 1'b0;
    end
    wait_ref(400);
    `CHK(ovrSeen, 1'b1)
    `CHK(captureReady, 1'b0)
    nibQ.delete();
    @(posedge refClk) payloadReady <= 1'b1;
    wait_ref(100);
    chk_seq(nibQ, 8'h0f);
  endtask

  initial begin
    // short reset; the design stretches it for the link side on its own
    repeat (3) @(posedge refClk);
    rst <= 1'b0;
    wait_ref(20);
    test_nibble();
    test_link();
    test_idle();
    test_full();
    stop_test();
  end

endmodule // tb
